//--- rtl/awo_pkg.sv
package awo_pkg;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 7;
  localparam int PHASES = 4;
  localparam logic [7:0] ZERO_BYTE  = 8'h00;
  localparam logic [6:0] ADDR_MAX   = 7'h7f;
  localparam int MSB_BIT   = 7;
  localparam int NIB_BIT   = 3;
  localparam logic DEST_W   = 1'b0;
  localparam logic DEST_F   = 1'b1;

  typedef enum logic [2:0] {
    OP_ADD_WF = 3'b001,
    OP_AND_WF = 3'b010,
    OP_ADD_LW = 3'b100
  } awo_op_type;

  typedef enum logic [3:0] {
    PH_DECODE  = 4'b0001,
    PH_READ    = 4'b0010,
    PH_PROCESS = 4'b0100,
    PH_WRITE   = 4'b1000
  } awo_phase_type;

  typedef struct packed {
    awo_op_type  op;
    logic [6:0]  file_addr;
    logic        dest;
    logic [7:0]  literal;
  } awo_instr_type;

  typedef struct packed {
    logic carry;
    logic digit_carry_flag;
    logic zero;
  } awo_flags_type;
endpackage

//--- rtl/awo_alu.sv
`timescale 1ns/1ps
`default_nettype none
module awo_alu
  import awo_pkg::*;
(
  input  wire awo_pkg::awo_op_type op,
  input  wire logic [7:0]  a,
  input  wire logic [7:0]  b,
  output logic [7:0]       result,
  output logic             carry,
  output logic             digit_carry_flag
);
  import awo_pkg::*;

  logic [8:0] sum;
  logic [4:0] low_sum;
  always_comb begin
    sum     = {1'b0, a} + {1'b0, b};
    low_sum = {1'b0, a[NIB_BIT:0]} + {1'b0, b[NIB_BIT:0]};
    carry   = sum[MSB_BIT + 1];
    digit_carry_flag = low_sum[NIB_BIT + 1];
    if (op == OP_AND_WF) begin
      result = a & b;
    end else begin
      result = sum[MSB_BIT:0];
    end
  end
endmodule
`default_nettype wire

//--- rtl/awo_core.sv
// Summary of operation
// - Add-working-to-file sums W and file register, writes destination, updates carry, digit carry, zero.
// - Destination bit 0 writes W, bit 1 writes back the addressed file register.
// - AND-working-with-file ANDs W with file register, updates only the zero flag.
// - File operand is a 7-bit address, 0 to 127, into the single file register array.
// - One cycle of four phases: decode, read, process, write.
// - Add-literal adds 8-bit immediate to W, result to W, updates carry, digit carry, zero.
`timescale 1ns/1ps
`default_nettype none
module awo_core
  import awo_pkg::*;
#(
  parameter int FILE_DEPTH = 128
) (
  input  wire logic                   clk,
  input  wire logic                   rst_n,
  input  wire awo_pkg::awo_instr_type instr,
  input  wire logic                   instr_valid,
  output logic                        instr_ready,
  output logic                        done,
  output logic [7:0]                  working,
  output awo_pkg::awo_flags_type      flags
);
  import awo_pkg::*;

  awo_phase_type phase;
  awo_instr_type cur;
  logic [7:0]    file_regs [FILE_DEPTH];
  logic [7:0]    operand;
  logic [7:0]    result;
  logic [7:0]    alu_result;
  logic          alu_carry;
  logic          alu_digit_carry;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      phase <= PH_DECODE;
    end else begin
      unique case (phase)
        PH_DECODE: begin
          if (instr_valid) begin
            phase <= PH_READ;
          end
        end
        PH_READ:    phase <= PH_PROCESS;
        PH_PROCESS: phase <= PH_WRITE;
        PH_WRITE:   phase <= PH_DECODE;
        default:    phase <= PH_DECODE;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      instr_ready <= 1'b1;
      done        <= 1'b0;
    end else begin
      instr_ready <= (phase == PH_WRITE) || (phase == PH_DECODE && !instr_valid);
      done        <= (phase == PH_WRITE);
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cur <= '0;
    end else if (phase == PH_DECODE && instr_valid) begin
      cur <= instr;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      operand <= ZERO_BYTE;
    end else if (phase == PH_READ) begin
      operand <= (cur.op == OP_ADD_LW) ? cur.literal : file_regs[cur.file_addr];
    end
  end

  awo_alu u_alu (
    .op               (cur.op),
    .a                (working),
    .b                (operand),
    .result           (alu_result),
    .carry            (alu_carry),
    .digit_carry_flag (alu_digit_carry)
  );

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      result <= ZERO_BYTE;
    end else if (phase == PH_PROCESS) begin
      result <= alu_result;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      working <= ZERO_BYTE;
    end else if (phase == PH_WRITE) begin
      if (cur.op == OP_ADD_LW || cur.dest == DEST_W) begin
        working <= result;
      end
    end
  end

  // Storage left unreset; software initialises file registers
  always_ff @(posedge clk) begin
    if (phase == PH_WRITE && cur.op != OP_ADD_LW && cur.dest == DEST_F) begin
      file_regs[cur.file_addr] <= result;
    end
  end

  logic carry_q;
  logic digit_carry_q;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      carry_q       <= 1'b0;
      digit_carry_q <= 1'b0;
    end else if (phase == PH_PROCESS) begin
      carry_q       <= alu_carry;
      digit_carry_q <= alu_digit_carry;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      flags <= '0;
    end else if (phase == PH_WRITE) begin
      flags.zero <= (result == ZERO_BYTE);
      if (cur.op != OP_AND_WF) begin
        flags.carry            <= carry_q;
        flags.digit_carry_flag <= digit_carry_q;
      end
    end
  end

  logic [7:0] w_at_read;
  logic [7:0] op_at_read;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      w_at_read  <= ZERO_BYTE;
      op_at_read <= ZERO_BYTE;
    end else if (phase == PH_PROCESS) begin
      w_at_read  <= working;
      op_at_read <= operand;
    end
  end

  chk_phase_order: assert property (@(posedge clk) disable iff (!rst_n)
    (phase == PH_READ) |=> (phase == PH_PROCESS) ##1 (phase == PH_WRITE) ##1 (phase == PH_DECODE))
    else $error("phase order broken");
  chk_done_after: assert property (@(posedge clk) disable iff (!rst_n)
    (phase == PH_WRITE) |=> done) else $error("done missing");
  chk_add_to_w: assert property (@(posedge clk) disable iff (!rst_n)
    (phase == PH_WRITE && cur.op == OP_ADD_WF && cur.dest == DEST_W)
    |=> working == 8'(w_at_read + op_at_read)) else $error("add result wrong");
  chk_and_to_w: assert property (@(posedge clk) disable iff (!rst_n)
    (phase == PH_WRITE && cur.op == OP_AND_WF && cur.dest == DEST_W)
    |=> working == (w_at_read & op_at_read)) else $error("and result wrong");
  chk_dest_file: assert property (@(posedge clk) disable iff (!rst_n)
    (phase == PH_WRITE && cur.op != OP_ADD_LW && cur.dest == DEST_F)
    |=> $stable(working)) else $error("W changed on file dest");
  chk_and_flags: assert property (@(posedge clk) disable iff (!rst_n)
    (phase == PH_WRITE && cur.op == OP_AND_WF)
    |=> $stable(flags.carry) && $stable(flags.digit_carry_flag))
    else $error("and touched carry");
  chk_zero_flag: assert property (@(posedge clk) disable iff (!rst_n)
    (phase == PH_WRITE) |=> flags.zero == ($past(result) == ZERO_BYTE))
    else $error("zero flag wrong");
  chk_carry_flag: assert property (@(posedge clk) disable iff (!rst_n)
    (phase == PH_WRITE && cur.op != OP_AND_WF)
    |=> flags.carry == ((9'(w_at_read) + 9'(op_at_read)) > 9'h0ff))
    else $error("carry flag wrong");
  chk_digit_flag: assert property (@(posedge clk) disable iff (!rst_n)
    (phase == PH_WRITE && cur.op != OP_AND_WF)
    |=> flags.digit_carry_flag ==
        ((5'(w_at_read[NIB_BIT:0]) + 5'(op_at_read[NIB_BIT:0])) > 5'h0f))
    else $error("digit carry flag wrong");
  chk_literal_w: assert property (@(posedge clk) disable iff (!rst_n)
    (phase == PH_WRITE && cur.op == OP_ADD_LW)
    |=> working == 8'(w_at_read + op_at_read)) else $error("literal add wrong");
endmodule
`default_nettype wire

//--- sim/awo_core_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module awo_core_tb_top;
  import awo_pkg::*;
  logic          clk         = 1'b0;
  logic          rst_n       = 1'b0;
  awo_instr_type instr       = '0;
  logic          instr_valid = 1'b0;
  logic          instr_ready;
  logic          done;
  logic [7:0]    working;
  awo_flags_type flags;
  int            err_count       = 0;
  int            samples_checked = 0;
  int            seed            = 82585;
  logic [7:0]    m_w             = 8'h00;
  logic [7:0]    m_file [128];
  awo_flags_type m_fl            = '0;
  awo_op_type    ops [3]         = '{OP_ADD_WF, OP_AND_WF, OP_ADD_LW};

  always #2.5 clk = ~clk;

  awo_core #(.FILE_DEPTH(128)) i_awo_core (
    .clk         (clk),
    .rst_n       (rst_n),
    .instr       (instr),
    .instr_valid (instr_valid),
    .instr_ready (instr_ready),
    .done        (done),
    .working     (working),
    .flags       (flags)
  );

  task test_done;
    $display("Checks %0d, mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task chkf(input string nm, input awo_flags_type e, input awo_flags_type g);
    samples_checked++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %s expected %b seen %b", nm, e, g);
    end
  endtask

  // Selector instead of a ref argument: 0 waits for instr_ready, 1 for done
  task automatic wait_hi(input bit sel, input string nm);
    int n;
    n = 0;
    while ((sel ? done : instr_ready) !== 1'b1 && n < 20) begin
      @(negedge clk);
      n++;
    end
    if ((sel ? done : instr_ready) !== 1'b1) begin
      err_count++;
      $display("[FAIL] %s expected 1 seen timeout", nm);
      test_done;
    end
  endtask

  // Bench model of one instruction, then drive and compare
  task run(input awo_op_type op, input logic [6:0] a, input logic d, input logic [7:0] k);
    logic [7:0] x;
    logic [8:0] s;
    logic [4:0] h;
    x = (op == OP_ADD_LW) ? k : m_file[a];
    s = (op == OP_AND_WF) ? {1'b0, m_w & x} : {1'b0, m_w} + {1'b0, x};
    h = {1'b0, m_w[3:0]} + {1'b0, x[3:0]};
    if (op != OP_AND_WF) begin
      m_fl.carry = s[8];
      m_fl.digit_carry_flag = h[4];
    end
    m_fl.zero = (s[7:0] == ZERO_BYTE);
    if (op != OP_ADD_LW && d == DEST_F) m_file[a] = s[7:0];
    else m_w = s[7:0];
    wait_hi(1'b0, "instr_ready");
    instr = '{op, a, d, k};
    instr_valid = 1'b1;
    @(negedge clk);
    instr_valid = 1'b0;
    // Single cycle of four phases
    wait_hi(1'b1, "done");
    chk8("working", m_w, working); // Result and destination
    chkf("flags", m_fl, flags); // Flag updates
    @(negedge clk);
    chk8("done_pulse", 8'h00, 8'(done));
  endtask

  initial begin
    logic [31:0] r;
    repeat (20) @(negedge clk);
    rst_n = 1'b1;
    @(negedge clk);
    chk8("working_reset", 8'h00, working);
    chkf("flags_reset", '0, flags);
    $display("Test reset done");
    // W is zero, so AND clears every file register, top address too
    for (int i = 0; i < 128; i++) run(OP_AND_WF, i[6:0], DEST_F, 8'h00);
    $display("Test file clear done");
    run(OP_ADD_LW, 7'h00, DEST_F, 8'h0f);
    run(OP_ADD_LW, 7'h00, DEST_W, 8'h01);
    run(OP_ADD_WF, 7'h7f, DEST_F, 8'h00);
    run(OP_ADD_LW, 7'h00, DEST_W, 8'hf0);
    run(OP_ADD_WF, 7'h7f, DEST_W, 8'h00);
    run(OP_AND_WF, 7'h7f, DEST_W, 8'h00);
    $display("Test corner cases done");
    for (int i = 0; i < 300; i++) begin
      r = $random(seed);
      run(ops[r[1:0] % 3], r[8:2], r[9], r[17:10]);
    end
    $display("Test random done");
    test_done;
  end
endmodule
`default_nettype wire
